// ---- include/pchr_pkg.sv ----
// Constants and carrier types for the capability header register bank.
package pchr_pkg;

  // ********************************************************
  // Bus geometry and register map
  // ********************************************************
  localparam int         WB_AW       = 8;
  localparam int         WB_DW       = 32;
  localparam logic [7:0] HDR_OFF     = 8'h40;
  localparam logic [7:0] DCAP_OFF    = 8'h44;
  localparam logic [7:0] CTL_OFF     = 8'hF0;
  localparam logic [7:0] STS_OFF     = 8'hF4;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  // ********************************************************
  // Capability header fields
  // ********************************************************
  localparam int         CAPABILITY_IDENTIFIER_LSB   = 0;
  localparam logic [7:0] CAPABILITY_IDENTIFIER_VAL   = 8'h10;
  localparam int         NXT_LSB     = 8;
  localparam logic [7:0] NXT_VAL     = 8'h70;
  localparam int         REV_LSB     = 16;
  localparam logic [3:0] REV_VAL     = 4'h1;
  localparam int         PTYPE_LSB   = 20;
  localparam logic [3:0] PTYPE_UP    = 4'h5;
  localparam logic [3:0] PTYPE_DN    = 4'h6;
  localparam int         SLOT_BIT    = 24;
  localparam logic       SLOT_RST    = 1'h0;
  localparam int         MSI_LSB     = 25;
  localparam logic [4:0] MSI_VAL     = 5'h0;

  // ********************************************************
  // Device capabilities fields
  // ********************************************************
  localparam int         MPS_LSB     = 0;
  localparam logic [2:0] MPS_RST     = 3'h4;
  localparam int         PFS_LSB     = 3;
  localparam logic [1:0] PFS_VAL     = 2'h0;
  localparam int         EXTENDED_TAG_SUPPORT_BIT    = 5;
  localparam logic       EXTENDED_TAG_SUPPORT_VAL    = 1'h1;
  localparam int         L0S_LSB     = 6;
  localparam logic [2:0] L0S_VAL     = 3'h0;
  localparam int         L1_LSB      = 9;
  localparam logic [2:0] L1_VAL      = 3'h0;
  localparam int         ABP_BIT     = 12;
  localparam int         AIP_BIT     = 13;
  localparam int         PIP_BIT     = 14;
  localparam logic       FLAG_RST    = 1'h0;
  localparam int         CSPL_LSB    = 18;
  localparam logic [7:0] CSPL_RST    = 8'h00;
  localparam logic [1:0] SCALE_RST   = 2'h0;

  // ********************************************************
  // Local control and status fields
  // ********************************************************
  localparam int         LOCK_BIT    = 0;
  localparam logic       LOCK_RST    = 1'h0;
  localparam int         STS_PT_LSB  = 0;
  localparam int         STS_SC_LSB  = 4;
  localparam int         STS_UP_BIT  = 8;
  localparam int         STS_RDY_BIT = 9;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [0:0] {
    STRAP_WAIT = 1'b0,
    STRAP_DONE = 1'b1
  } pchr_strap_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pchr_wb_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [1:0] scale;
  } pchr_spl_msg_s;

endpackage

// ---- hdl/pchr_wb_port.sv ----
// Classic Wishbone slave handshake with registered acknowledge and read data.
`timescale 1ns/10ps
`default_nettype none
module pchr_wb_port (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  ce,
  input  wire pchr_pkg::pchr_wb_req_s req,
  input  wire logic [31:0]           rd_data,
  output logic                       take,
  output logic                       ack,
  output logic [31:0]                dat
);
  import pchr_pkg::*;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } pchr_wbp_s;

  pchr_wbp_s st_q;
  pchr_wbp_s st_d;

  // A request is taken once; the ack cycle itself blocks a second take.
  assign take = ce & req.cyc & req.stb & ~st_q.ack;

  always_comb begin
    st_d     = st_q;
    st_d.ack = take;
    if (take) begin
      st_d.dat = req.we ? WORD_ZERO : rd_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '{ack: 1'b0, dat: WORD_ZERO};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign ack = st_q.ack;
  assign dat = st_q.dat;
endmodule
`default_nettype wire

// ---- hdl/pchr_spl_capture.sv ----
// Holder for the slot power limit value and scale received on the upstream link.
`timescale 1ns/10ps
`default_nettype none
module pchr_spl_capture (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  input  wire logic                   is_upstream,
  input  wire pchr_pkg::pchr_spl_msg_s msg,
  output logic [7:0]                  value,
  output logic [1:0]                  scale
);
  import pchr_pkg::*;

  typedef struct packed {
    logic [7:0] value;
    logic [1:0] scale;
  } pchr_spl_s;

  pchr_spl_s st_q;
  pchr_spl_s st_d;

  always_comb begin
    st_d = st_q;
    if (!is_upstream) begin
      st_d.value = CSPL_RST; // [RQ13]
      st_d.scale = SCALE_RST;
    end else if (msg.valid) begin
      st_d.value = msg.value; // [RQ13]
      st_d.scale = msg.scale; // [RQ14]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '{value: CSPL_RST, scale: SCALE_RST};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign value = st_q.value;
  assign scale = st_q.scale;
endmodule
`default_nettype wire

// ---- hdl/pchr_regs.sv ----
// Capability header and device capabilities register bank of one switch port.
//
// Behaviour
// [RQ1] Header bits 7:0 always read the capability identifier 0x10.
// [RQ2] Header bits 15:8 always read next capability pointer 0x70.
// [RQ3] Header bits 19:16 always read structure revision 0x1.
// [RQ4] Header bit 24 slot flag resets to zero, writable while unlocked.
// [RQ5] Header bits 29:25 message vector index always read zero.
// [RQ6] Payload supported bits 2:0 reset to 0x4, writable while unlocked.
// [RQ7] Phantom function support bits 4:3 always read zero.
// [RQ8] Extended tag support bit 5 always reads one.
// [RQ9] Shallow standby exit tolerance bits 8:6 always read zero.
// [RQ10] Deep low-power exit tolerance bits 11:9 always read zero.
// [RQ11] Button, attention lamp, power lamp flags reset zero, writable while unlocked.
// [RQ12] Software should leave the three presence flags clear on downstream ports.
// [RQ13] Power limit bits 25:18 load from upstream messages, zero downstream.
// [RQ14] Software multiplies captured limit by the scale to obtain watts.
// [RQ15] Writes to fixed or reserved fields are dropped; they read fixed values.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module pchr_regs (
  input  wire logic                    CLK,
  input  wire logic                    RESET,
  input  wire logic                    CE,
  input  wire pchr_pkg::pchr_wb_req_s  WB_REQ,
  output logic                         WB_ACK_O,
  output logic [31:0]                  WB_DAT_O,
  input  wire logic                    PORT_UPSTREAM_STRAP,
  input  wire pchr_pkg::pchr_spl_msg_s SPL_MSG,
  output logic                         SLOT_IMPLEMENTED,
  output logic [2:0]                   MAX_PAYLOAD_SUPPORTED,
  output logic                         ATTENTION_BUTTON_FLAG,
  output logic                         ATTENTION_LAMP_FLAG,
  output logic                         POWER_LAMP_FLAG,
  output logic                         CONFIG_LOCKED
);
  import pchr_pkg::*;

  // ********************************************************
  // State
  // ********************************************************
  // The strap is captured once after reset release, so that the
  // asynchronous reset only ever loads constants.
  typedef struct packed {
    pchr_strap_e strap_st;
    logic        is_up;
    logic        slot;
    logic [2:0]  mps;
    logic        attention_button_flag;
    logic        attention_lamp_flag;
    logic        power_lamp_flag;
    logic        lock;
  } pchr_regs_s;

  localparam pchr_regs_s RESET_STATE = '{
    strap_st: STRAP_WAIT,
    is_up:    1'b0,
    slot:     SLOT_RST,
    mps:      MPS_RST,
    attention_button_flag:      FLAG_RST,
    attention_lamp_flag:      FLAG_RST,
    power_lamp_flag:      FLAG_RST,
    lock:     LOCK_RST
  };

  pchr_regs_s  st_q;
  pchr_regs_s  st_d;
  logic        take;
  logic [31:0] rd_data;
  logic [31:0] hdr_word;
  logic [31:0] dcap_word;
  logic [31:0] ctl_word;
  logic [31:0] sts_word;
  logic [31:0] wr_hdr;
  logic [31:0] wr_dcap;
  logic [31:0] wr_ctl;
  logic [7:0]  cspl_value;
  logic [1:0]  cspl_scale;
  logic        wr_en;

  // ********************************************************
  // Helper functions
  // ********************************************************
  // Merges write data into an old word lane by lane under the byte selects.
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // True when the given address falls in the same 32-bit word as the given offset.
  function automatic logic hits(
    input logic [7:0] adr,
    input logic [7:0] off
  );
    return adr[7:2] == off[7:2];
  endfunction

  // ********************************************************
  // Bus slave
  // ********************************************************
  pchr_wb_port u_wb (
    .clk     (CLK),
    .reset   (RESET),
    .ce      (CE),
    .req     (WB_REQ),
    .rd_data (rd_data),
    .take    (take),
    .ack     (WB_ACK_O),
    .dat     (WB_DAT_O)
  );

  assign wr_en = take & WB_REQ.we;

  // ********************************************************
  // Slot power limit capture
  // ********************************************************
  pchr_spl_capture u_spl (
    .clk         (CLK),
    .reset       (RESET),
    .ce          (CE),
    .is_upstream (st_q.is_up),
    .msg         (SPL_MSG),
    .value       (cspl_value),
    .scale       (cspl_scale)
  );

  // ********************************************************
  // Read words
  // ********************************************************
  // Every fixed field is rebuilt from constants on each read, so no
  // write can ever disturb it; bits 31:30 are left at zero.
  always_comb begin
    hdr_word = WORD_ZERO;
    hdr_word[CAPABILITY_IDENTIFIER_LSB +: 8] = CAPABILITY_IDENTIFIER_VAL; // [RQ1]
    hdr_word[NXT_LSB +: 8] = NXT_VAL; // [RQ2]
    hdr_word[REV_LSB +: 4] = REV_VAL; // [RQ3]
    hdr_word[PTYPE_LSB +: 4] = st_q.is_up ? PTYPE_UP : PTYPE_DN;
    hdr_word[SLOT_BIT] = st_q.slot; // [RQ4]
    hdr_word[MSI_LSB +: 5] = MSI_VAL; // [RQ5]
  end

  always_comb begin
    dcap_word = WORD_ZERO;
    dcap_word[MPS_LSB +: 3] = st_q.mps; // [RQ6]
    dcap_word[PFS_LSB +: 2] = PFS_VAL; // [RQ7]
    dcap_word[EXTENDED_TAG_SUPPORT_BIT] = EXTENDED_TAG_SUPPORT_VAL; // [RQ8]
    dcap_word[L0S_LSB +: 3] = L0S_VAL; // [RQ9]
    dcap_word[L1_LSB +: 3] = L1_VAL; // [RQ10]
    dcap_word[ABP_BIT] = st_q.attention_button_flag; // [RQ11]
    dcap_word[AIP_BIT] = st_q.attention_lamp_flag; // [RQ11]
    dcap_word[PIP_BIT] = st_q.power_lamp_flag; // [RQ11]
    dcap_word[CSPL_LSB +: 8] = cspl_value; // [RQ13]
  end

  always_comb begin
    ctl_word = WORD_ZERO;
    ctl_word[LOCK_BIT] = st_q.lock;
  end

  // The scale sits here so software can form the power ceiling.
  always_comb begin
    sts_word = WORD_ZERO;
    sts_word[STS_PT_LSB +: 4] = hdr_word[PTYPE_LSB +: 4];
    sts_word[STS_SC_LSB +: 2] = cspl_scale; // [RQ14]
    sts_word[STS_UP_BIT] = st_q.is_up;
    sts_word[STS_RDY_BIT] = (st_q.strap_st == STRAP_DONE);
  end

  // Unmapped offsets read as zero and still receive an acknowledge.
  always_comb begin
    rd_data = WORD_ZERO;
    if (hits(WB_REQ.adr, HDR_OFF)) begin
      rd_data = hdr_word;
    end else if (hits(WB_REQ.adr, DCAP_OFF)) begin
      rd_data = dcap_word;
    end else if (hits(WB_REQ.adr, CTL_OFF)) begin
      rd_data = ctl_word;
    end else if (hits(WB_REQ.adr, STS_OFF)) begin
      rd_data = sts_word;
    end
  end

  // ********************************************************
  // Write merge
  // ********************************************************
  assign wr_hdr  = lane_merge(hdr_word, WB_REQ.dat, WB_REQ.sel);
  assign wr_dcap = lane_merge(dcap_word, WB_REQ.dat, WB_REQ.sel);
  assign wr_ctl  = lane_merge(ctl_word, WB_REQ.dat, WB_REQ.sel);

  // ********************************************************
  // Next state
  // ********************************************************
  // Lockable fields take writes only while the lock bit is clear; the
  // lock bit itself stays writable so firmware can reopen the bank.
  always_comb begin
    st_d = st_q;
    case (st_q.strap_st)
      STRAP_WAIT: begin
        st_d.is_up    = PORT_UPSTREAM_STRAP;
        st_d.strap_st = STRAP_DONE;
      end
      STRAP_DONE: begin
        st_d.strap_st = STRAP_DONE;
      end
      default: begin
        st_d.strap_st = STRAP_WAIT;
      end
    endcase
    if (wr_en && !st_q.lock) begin
      if (hits(WB_REQ.adr, HDR_OFF)) begin
        st_d.slot = wr_hdr[SLOT_BIT]; // [RQ4] [RQ15]
      end
      if (hits(WB_REQ.adr, DCAP_OFF)) begin
        st_d.mps = wr_dcap[MPS_LSB +: 3]; // [RQ6] [RQ15]
        st_d.attention_button_flag = wr_dcap[ABP_BIT]; // [RQ11]
        st_d.attention_lamp_flag = wr_dcap[AIP_BIT]; // [RQ11]
        st_d.power_lamp_flag = wr_dcap[PIP_BIT]; // [RQ11]
      end
    end
    if (wr_en && hits(WB_REQ.adr, CTL_OFF)) begin
      st_d.lock = wr_ctl[LOCK_BIT];
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_q <= RESET_STATE;
    end else if (CE) begin
      st_q <= st_d;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign SLOT_IMPLEMENTED      = st_q.slot;
  assign MAX_PAYLOAD_SUPPORTED = st_q.mps;
  assign ATTENTION_BUTTON_FLAG = st_q.attention_button_flag;
  assign ATTENTION_LAMP_FLAG   = st_q.attention_lamp_flag;
  assign POWER_LAMP_FLAG       = st_q.power_lamp_flag;
  assign CONFIG_LOCKED         = st_q.lock;
endmodule
`default_nettype wire

// ---- dv/pchr_regs_asserts.sv ----
// Concurrent checks on the ports of the capability header register bank.
`timescale 1ns/10ps
`default_nettype none
module pchr_regs_asserts (
  input wire logic                    CLK,
  input wire logic                    RESET,
  input wire logic                    CE,
  input wire pchr_pkg::pchr_wb_req_s  WB_REQ,
  input wire logic                    WB_ACK_O,
  input wire logic [31:0]             WB_DAT_O,
  input wire logic                    PORT_UPSTREAM_STRAP,
  input wire pchr_pkg::pchr_spl_msg_s SPL_MSG,
  input wire logic                    SLOT_IMPLEMENTED,
  input wire logic [2:0]              MAX_PAYLOAD_SUPPORTED,
  input wire logic                    ATTENTION_BUTTON_FLAG,
  input wire logic                    ATTENTION_LAMP_FLAG,
  input wire logic                    POWER_LAMP_FLAG,
  input wire logic                    CONFIG_LOCKED
);
  import pchr_pkg::*;
  logic       we_q;
  logic [5:0] word_q;
  wire logic  take    = CE && WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O;
  wire logic  hdr_r   = WB_ACK_O && !we_q && word_q == 6'h10;
  wire logic  dcap_r  = WB_ACK_O && !we_q && word_q == 6'h11;
  wire logic  wr_hdr  = take && WB_REQ.we && WB_REQ.adr[7:2] == 6'h10;
  wire logic  wr_dcap = take && WB_REQ.we && WB_REQ.adr[7:2] == 6'h11;
  // The acknowledge answers the request taken one edge earlier, so remember which it was.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      we_q   <= 1'b0;
      word_q <= 6'h00;
    end else if (take) begin
      we_q   <= WB_REQ.we;
      word_q <= WB_REQ.adr[7:2];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  capability_identifier_a: assert property (hdr_r |-> WB_DAT_O[7:0] == CAPABILITY_IDENTIFIER_VAL)
    else $error("capability identifier wrong");
  next_ptr_a: assert property (hdr_r |-> WB_DAT_O[15:8] == NXT_VAL)
    else $error("next pointer wrong");
  revision_a: assert property (hdr_r |-> WB_DAT_O[19:16] == REV_VAL)
    else $error("structure revision wrong");
  slot_write_a: assert property (wr_hdr && WB_REQ.sel[3] && !CONFIG_LOCKED |=> SLOT_IMPLEMENTED == $past(WB_REQ.dat[24]))
    else $error("slot flag not written");
  msi_zero_a: assert property (hdr_r |-> WB_DAT_O[31:25] == 7'h00 && WB_DAT_O[24] == SLOT_IMPLEMENTED)
    else $error("header upper bits wrong");
  mps_write_a: assert property (wr_dcap && WB_REQ.sel[0] && !CONFIG_LOCKED |=> MAX_PAYLOAD_SUPPORTED == $past(WB_REQ.dat[2:0]))
    else $error("payload field not written");
  dcap_fixed_a: assert property (dcap_r |-> WB_DAT_O[11:3] == 9'h004 && WB_DAT_O[2:0] == MAX_PAYLOAD_SUPPORTED)
    else $error("fixed capability bits wrong");
  flags_read_a: assert property (dcap_r |-> WB_DAT_O[14:12] == {POWER_LAMP_FLAG, ATTENTION_LAMP_FLAG, ATTENTION_BUTTON_FLAG})
    else $error("presence flags misread");
  lock_hold_a: assert property ((wr_dcap || wr_hdr) && CONFIG_LOCKED |=> $stable({SLOT_IMPLEMENTED, MAX_PAYLOAD_SUPPORTED, POWER_LAMP_FLAG, ATTENTION_LAMP_FLAG, ATTENTION_BUTTON_FLAG}))
    else $error("locked field changed");
  reserved_a: assert property (dcap_r |-> WB_DAT_O[17:15] == 3'h0 && WB_DAT_O[31:26] == 6'h00)
    else $error("reserved bits set");
  ack_pulse_a: assert property (WB_ACK_O && CE |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");
endmodule
bind pchr_regs pchr_regs_asserts chk (.CLK(CLK), .RESET(RESET), .CE(CE), .WB_REQ(WB_REQ), .WB_ACK_O(WB_ACK_O),
  .WB_DAT_O(WB_DAT_O), .PORT_UPSTREAM_STRAP(PORT_UPSTREAM_STRAP), .SPL_MSG(SPL_MSG),
  .SLOT_IMPLEMENTED(SLOT_IMPLEMENTED), .MAX_PAYLOAD_SUPPORTED(MAX_PAYLOAD_SUPPORTED),
  .ATTENTION_BUTTON_FLAG(ATTENTION_BUTTON_FLAG), .ATTENTION_LAMP_FLAG(ATTENTION_LAMP_FLAG),
  .POWER_LAMP_FLAG(POWER_LAMP_FLAG), .CONFIG_LOCKED(CONFIG_LOCKED));
`default_nettype wire

// ---- dv/pchr_regs_bench.sv ----
// Self-checking bench for the capability header register bank.
`timescale 1ns/10ps
`default_nettype none
module pchr_regs_bench;
  import pchr_pkg::*;
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  logic          strap = 1'b0;
  logic          ce = 1'b1;
  pchr_wb_req_s  req = '0;
  pchr_spl_msg_s msg = '0;
  logic          ack, slot, btn, alamp, plamp, locked;
  logic [2:0]    mps;
  logic [31:0]   dat, r;
  logic [31:0]   rng = 32'h0000_0053;
  logic [31:0]   exp_q[$];
  int            n_fail = 0;
  int            comparisons = 0;
  always #12.5 clk = ~clk;
  pchr_regs uut (.CLK(clk), .RESET(reset), .CE(ce), .WB_REQ(req), .WB_ACK_O(ack), .WB_DAT_O(dat),
    .PORT_UPSTREAM_STRAP(strap), .SPL_MSG(msg), .SLOT_IMPLEMENTED(slot), .MAX_PAYLOAD_SUPPORTED(mps),
    .ATTENTION_BUTTON_FLAG(btn), .ATTENTION_LAMP_FLAG(alamp), .POWER_LAMP_FLAG(plamp), .CONFIG_LOCKED(locked));
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", what, e, s);
      n_fail++;
    end
  endtask
  // Level outputs packed as lock, power lamp, attention lamp, button, slot, payload.
  task automatic chk_pins(input logic [7:0] e);
    chk("output pins", {24'h00_0000, e}, {24'h00_0000, locked, plamp, alamp, btn, slot, mps});
  endtask
  // One classic cycle; the expected answer is queued for the monitor before the request goes out.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] d,
                     input logic [31:0] e);
    int i;
    exp_q.push_back(e);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      chk("acknowledge", 32'h0000_0001, 32'h0000_0000);
      stop_test();
    end
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask
  task automatic send_msg(input logic [7:0] v, input logic [1:0] s);
    @(posedge clk);
    msg <= '{valid: 1'b1, value: v, scale: s};
    @(posedge clk);
    msg <= '{valid: 1'b0, value: ~v, scale: ~s};
  endtask
  task automatic do_reset(input logic up);
    @(posedge clk);
    reset <= 1'b1;
    strap <= up;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected acknowledge", 32'h0000_0000, 32'h0000_0001);
      else chk("bus data", exp_q.pop_front(), dat);
    end
  end
  initial begin
    do_reset(1'b0);
    chk_pins(8'h04);
    bus(1'b0, HDR_OFF, 4'hF, WORD_ZERO, 32'h0061_7010);
    bus(1'b0, DCAP_OFF, 4'hF, WORD_ZERO, 32'h0000_0024);
    send_msg(8'hA5, 2'h1);
    bus(1'b0, DCAP_OFF, 4'hF, WORD_ZERO, 32'h0000_0024);
    bus(1'b1, HDR_OFF, 4'hF, 32'hFFFF_FFFF, WORD_ZERO);
    bus(1'b0, HDR_OFF, 4'hF, WORD_ZERO, 32'h0161_7010);
    bus(1'b1, DCAP_OFF, 4'hF, 32'hFFFF_FFFF, WORD_ZERO);
    bus(1'b0, DCAP_OFF, 4'hF, WORD_ZERO, 32'h0000_7027);
    bus(1'b1, DCAP_OFF, 4'h2, WORD_ZERO, WORD_ZERO);
    bus(1'b0, DCAP_OFF, 4'hF, WORD_ZERO, 32'h0000_0027);
    bus(1'b1, 8'h80, 4'hF, 32'hFFFF_FFFF, WORD_ZERO);
    bus(1'b0, 8'h80, 4'hF, WORD_ZERO, WORD_ZERO);
    bus(1'b1, CTL_OFF, 4'hF, 32'h0000_0001, WORD_ZERO);
    bus(1'b1, DCAP_OFF, 4'hF, 32'h0000_7007, WORD_ZERO);
    bus(1'b1, HDR_OFF, 4'hF, WORD_ZERO, WORD_ZERO);
    bus(1'b0, DCAP_OFF, 4'hF, WORD_ZERO, 32'h0000_0027);
    bus(1'b0, HDR_OFF, 4'hF, WORD_ZERO, 32'h0161_7010);
    chk_pins(8'h8F);
    $display("downstream port test done");
    do_reset(1'b1);
    bus(1'b0, HDR_OFF, 4'hF, WORD_ZERO, 32'h0051_7010);
    bus(1'b0, CTL_OFF, 4'hF, WORD_ZERO, WORD_ZERO);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      send_msg(r[7:0], r[9:8]);
      bus(1'b1, DCAP_OFF, 4'hF, r, WORD_ZERO);
      chk_pins({1'b0, r[14:12], 1'b0, r[2:0]});
      bus(1'b0, DCAP_OFF, 4'hF, WORD_ZERO, {6'h00, r[7:0], 18'h0_0020} | (r & 32'h0000_7007));
      bus(1'b0, STS_OFF, 4'hF, WORD_ZERO, {26'h000_000C, r[9:8], 4'h5});
    end
    $display("upstream port test done");
    // A message that arrives while the clock enable is low must be lost.
    @(posedge clk);
    ce <= 1'b0;
    send_msg(~r[7:0], ~r[9:8]);
    @(posedge clk);
    ce <= 1'b1;
    bus(1'b0, DCAP_OFF, 4'hF, WORD_ZERO, {6'h00, r[7:0], 18'h0_0020} | (r & 32'h0000_7007));
    bus(1'b0, STS_OFF, 4'hF, WORD_ZERO, {26'h000_000C, r[9:8], 4'h5});
    $display("clock enable test done");
    repeat (3) @(posedge clk);
    if (exp_q.size() != 0) chk("pending answers", 32'h0000_0000, 32'(exp_q.size()));
    stop_test();
  end
endmodule
`default_nettype wire
